// ---- rtl/rcmr_pkg.sv ----
// rcmr_pkg: constants, carriers and states of the manufacturer command responder.
// assumes a 25 MHz system clock and a host-driven SMBus clock.
`default_nettype none
package rcmr_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam logic [6:0] SLAVE_ADDR = 7'h58;
  localparam logic [7:0] CMD_FAN = 8'hD3;
  localparam logic [7:0] CMD_INPUT = 8'hD4;
  localparam logic [7:0] CMD_FWREV = 8'hD5;
  localparam logic [7:0] CMD_TIMER = 8'hD6;
  localparam logic [7:0] CMD_EEPROM = 8'hD9;
  localparam logic [7:0] CMD_TEST = 8'hDF;
  localparam logic [7:0] LEN_FAN = 8'h06;
  localparam logic [7:0] LEN_INPUT = 8'h0E;
  localparam logic [7:0] LEN_FWREV = 8'h03;
  localparam logic [7:0] LEN_TIMER = 8'h04;
  localparam int EE_DEPTH = 128;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam int TB_LEDTEST = 0;
  localparam int TB_SERVICE = 1;
  localparam int TB_ORING = 4;
  localparam int TB_STRETCH = 7;
  localparam int AB_OTWARN = 4;
  localparam logic [8:0] OT_WARN_MARGIN_C = 9'h005;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam int unsigned LEDTEST_ON_MS = 7000;
  localparam int unsigned LEDTEST_OFF_MS = 2000;
  localparam int unsigned SERVICE_ON_MS = 500;
  localparam int unsigned SERVICE_OFF_MS = 500;
  localparam int unsigned STRETCH_MS = 25;
  localparam int unsigned CC_HOLD_S = 20;
  localparam int unsigned HOUR_S = 3600;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned LEDTEST_ON_CYC = LEDTEST_ON_MS * MS_CYC;
  localparam int unsigned LEDTEST_OFF_CYC = LEDTEST_OFF_MS * MS_CYC;
  localparam int unsigned SERVICE_ON_CYC = SERVICE_ON_MS * MS_CYC;
  localparam int unsigned SERVICE_OFF_CYC = SERVICE_OFF_MS * MS_CYC;
  localparam int unsigned STRETCH_CYC = STRETCH_MS * MS_CYC;
  localparam int unsigned CC_HOLD_CYC = CC_HOLD_S * CLK_HZ;
  localparam longint unsigned HOUR_CYC = 64'(HOUR_S) * 64'(CLK_HZ);

  typedef struct packed {
    logic [15:0] pwrIn;
    logic [2:0][15:0] iPh;
    logic [2:0][15:0] vPh;
    logic [15:0] fan2Rpm;
    logic [15:0] fan1Rpm;
    logic [15:0] fanPct;
    logic [2:0][7:0] fwRev;
  } rcmr_meas_t;

  typedef struct packed {
    logic powerLimit;
    logic primaryFault;
    logic overtempShutdownFlag;
    logic inOvercurrent;
    logic overvoltageShutdownFlag;
    logic outputVoltageRangeFlag;
    logic inputVoltageRangeFlag;
  } rcmr_alarm_in_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACKOUT, ST_TX, ST_ACKIN} rcmr_state_t;
endpackage
`default_nettype wire

// ---- rtl/rcmr_crc8.sv ----
// rcmr_crc8: one byte step of the SMBus packet error code.
// purely combinational; the caller holds the running value.
`default_nettype none
module rcmr_crc8 (
  input wire logic [7:0] crcIn,  // running value
  input wire logic [7:0] dataIn, // byte on the wire
  output logic [7:0] crcOut      // updated value
);
  always_comb
  begin
    crcOut = crcIn ^ dataIn;
    for (int i = 0; i < 8; i++)
    begin
      crcOut = crcOut[7] ? ({crcOut[6:0], 1'b0} ^ rcmr_pkg::CRC_POLY) : {crcOut[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rcmr_blink.sv ----
// rcmr_blink: on/off flasher, starts lit when enabled, dark at once when not.
// assumes the enable is a register on the same clock.
`default_nettype none
module rcmr_blink #(
  parameter int unsigned ON_CYC = 2,
  parameter int unsigned OFF_CYC = 2
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic en,  // flashing wanted
  output logic led      // lamp drive, registered
);
  logic [31:0] cntReg, cntNext;
  logic phReg, phNext, ledReg, ledNext;

  always_comb
  begin
    cntNext = cntReg + 32'h00000001;
    phNext = phReg;
    if (!en)
    begin
      cntNext = '0;
      phNext = 1'b1;
    end
    else if (phReg && cntReg == ON_CYC - 1)
    begin
      cntNext = '0;
      phNext = 1'b0;
    end
    else if (!phReg && cntReg == OFF_CYC - 1)
    begin
      cntNext = '0;
      phNext = 1'b1;
    end
    ledNext = en & phNext;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cntReg <= '0;
      phReg <= 1'b1;
      ledReg <= 1'b0;
    end
    else
    begin
      cntReg <= cntNext;
      phReg <= phNext;
      ledReg <= ledNext;
    end
  end

  assign led = ledReg;
endmodule
`default_nettype wire

// ---- rtl/rcmr_responder.sv ----
// rcmr_responder: SMBus slave answering the manufacturer commands of a rectifier.
// assumes scl/sda arrive unsynchronised from the host; pins are open drain.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module rcmr_responder #(
  parameter int unsigned LEDTEST_ON_CYC = rcmr_pkg::LEDTEST_ON_CYC,
  parameter int unsigned LEDTEST_OFF_CYC = rcmr_pkg::LEDTEST_OFF_CYC,
  parameter int unsigned SERVICE_ON_CYC = rcmr_pkg::SERVICE_ON_CYC,
  parameter int unsigned SERVICE_OFF_CYC = rcmr_pkg::SERVICE_OFF_CYC,
  parameter int unsigned STRETCH_CYC = rcmr_pkg::STRETCH_CYC,
  parameter int unsigned CC_HOLD_CYC = rcmr_pkg::CC_HOLD_CYC,
  parameter longint unsigned HOUR_CYC = rcmr_pkg::HOUR_CYC
) (
  input wire logic clk,                       // 25 MHz clock
  input wire logic rst,                       // sync reset, high
  input wire logic sclIn,                     // bus clock pin level
  input wire logic sdaIn,                     // bus data pin level
  output logic sclOeN,                        // low: pull bus clock low
  output logic sdaOeN,                        // low: pull bus data low
  input wire rcmr_pkg::rcmr_meas_t meas,      // live measurements
  input wire logic fanPresent,                // fan fitted
  input wire logic [7:0] tempC,               // hottest sensor, degrees
  input wire logic [7:0] otShutLimit,         // shutdown level, degrees
  input wire rcmr_pkg::rcmr_alarm_in_t alarmIn, // other alarm sources
  input wire logic internalFault,             // true unit fault
  input wire logic oringFail,                 // isolation test failed
  input wire logic latchOffCfg,               // stored setting: latch off
  input wire logic overload,                  // output in current limit
  output logic [7:0] alarmByteOne,            // first alarm byte
  output logic [3:0] lampTestLeds,            // LED test drive
  output logic serviceLed,                    // ok-to-remove LED
  output logic oringTestReq,                  // OR'ing test running
  output logic oringFailNote,                 // status-only failure note
  output logic unitFault,                     // fault to system
  output logic autoRestart,                   // restart policy
  output logic ccHold,                        // constant-current hold
  output logic overloadTrip                   // overload protection acts
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus events
  logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD} <= 6'h3F;
    end
    else
    begin
      {sclS1, sclS2, sclD} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
    end
  end
  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise = sclS2 & ~sclD;
  assign sclFall = ~sclS2 & sclD;
  assign startCond = sclS2 & sclD & sdaD & ~sdaS2;
  assign stopCond = sclS2 & sclD & ~sdaD & sdaS2;

  ////////////////////////////////////////////////////////////////////////////
  // bus engine
  rcmr_pkg::rcmr_state_t stReg, stNext;
  logic [3:0] bitReg, bitNext;
  logic [7:0] shReg, shNext, txCur, txCurNext, cmdReg, cmdNext, wIdx, wIdxNext;
  logic [7:0] rIdx, rIdxNext, crcReg, crcNext, eeCnt, eeCntNext, testReg, testNext;
  logic [7:0] pendReg, pendNext, txByte, crcOut;
  logic [6:0] eeLoc, eeLocNext;
  logic isAddr, isAddrNext, rdMode, rdModeNext, pendOk, pendOkNext;
  logic sdaOeNNext, sclOeNNext, memWe;
  logic [31:0] strReg, strNext;
  logic [7:0] mem [rcmr_pkg::EE_DEPTH];
  logic [6:0] memAddr;

  rcmr_crc8 uCrc (
    .crcIn(crcReg),
    .dataIn(stReg == rcmr_pkg::ST_TX ? txCur : shReg),
    .crcOut(crcOut)
  );

  always_comb
  begin
    {stNext, bitNext, shNext, txCurNext} = {stReg, bitReg, shReg, txCur};
    {cmdNext, wIdxNext, rIdxNext, crcNext} = {cmdReg, wIdx, rIdx, crcReg};
    {eeCntNext, eeLocNext, testNext, pendNext} = {eeCnt, eeLoc, testReg, pendReg};
    {isAddrNext, rdModeNext, pendOkNext} = {isAddr, rdMode, pendOk};
    strNext = (strReg != 0) ? strReg - 32'h00000001 : '0;
    memWe = 1'b0;
    memAddr = 7'(eeLoc + 7'(wIdx - 8'h03));
    if (startCond)
    begin
      if (stReg == rcmr_pkg::ST_IDLE)
        crcNext = 8'h00;
      stNext = rcmr_pkg::ST_RX;
      isAddrNext = 1'b1;
      bitNext = '0;
    end
    else if (stopCond)
    begin
      // the test byte takes effect only once its PEC checks out
      if (pendOk && crcReg == 8'h00 && wIdx == 8'h03)
        testNext = pendReg;
      pendOkNext = 1'b0;
      stNext = rcmr_pkg::ST_IDLE;
    end
    else
    begin
      unique case (stReg)
        rcmr_pkg::ST_IDLE: ;
        rcmr_pkg::ST_RX:
          if (sclRise)
          begin
            shNext = {shReg[6:0], sdaS2};
            bitNext = bitReg + 4'h1;
          end
          else if (sclFall && bitReg == 4'h8)
          begin
            crcNext = crcOut;
            bitNext = '0;
            isAddrNext = 1'b0;
            if (isAddr)
            begin
              stNext = (shReg[7:1] == rcmr_pkg::SLAVE_ADDR) ? rcmr_pkg::ST_ACKOUT
                                                            : rcmr_pkg::ST_IDLE;
              rdModeNext = shReg[0];
              rIdxNext = '0;
              if (!shReg[0])
                wIdxNext = '0;
            end
            else
            begin
              stNext = rcmr_pkg::ST_ACKOUT;
              wIdxNext = wIdx + 8'h01;
              if (wIdx == 8'h00)
                cmdNext = shReg;
              else if (wIdx == 8'h01)
              begin
                eeLocNext = shReg[6:0];
                pendNext = shReg;
                pendOkNext = (cmdReg == rcmr_pkg::CMD_TEST);
              end
              else if (wIdx == 8'h02)
                eeCntNext = shReg;
              else if (cmdReg == rcmr_pkg::CMD_EEPROM && (wIdx - 8'h03) < eeCnt)
                memWe = 1'b1;
            end
          end
        rcmr_pkg::ST_ACKOUT:
          if (sclFall)
          begin
            stNext = rdMode ? rcmr_pkg::ST_TX : rcmr_pkg::ST_RX;
            if (rdMode)
            begin
              shNext = txByte;
              txCurNext = txByte;
            end
            if (testReg[rcmr_pkg::TB_STRETCH])
              strNext = STRETCH_CYC;
          end
        rcmr_pkg::ST_TX:
          if (sclFall)
          begin
            shNext = {shReg[6:0], 1'b1};
            bitNext = bitReg + 4'h1;
            if (bitReg == 4'h7)
            begin
              crcNext = crcOut;
              bitNext = '0;
              stNext = rcmr_pkg::ST_ACKIN;
            end
          end
        rcmr_pkg::ST_ACKIN:
          if (sclRise)
          begin
            if (sdaS2)
              stNext = rcmr_pkg::ST_IDLE;
            else
              rIdxNext = rIdx + 8'h01;
          end
          else if (sclFall)
          begin
            stNext = rcmr_pkg::ST_TX;
            shNext = txByte;
            txCurNext = txByte;
          end
      endcase
    end
    sdaOeNNext = !((stNext == rcmr_pkg::ST_ACKOUT) || (stNext == rcmr_pkg::ST_TX && !shNext[7]));
    sclOeNNext = (strNext == 0);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stReg <= rcmr_pkg::ST_IDLE;
      {bitReg, shReg, txCur, cmdReg, wIdx, rIdx, crcReg} <= '0;
      {eeCnt, eeLoc, pendReg, isAddr, rdMode, pendOk, strReg} <= '0;
      testReg <= rcmr_pkg::TEST_RESET;
      sdaOeN <= 1'b1;
      sclOeN <= 1'b1;
    end
    else
    begin
      {stReg, bitReg, shReg, txCur, cmdReg, wIdx, rIdx} <=
        {stNext, bitNext, shNext, txCurNext, cmdNext, wIdxNext, rIdxNext};
      {crcReg, eeCnt, eeLoc, pendReg, testReg} <= {crcNext, eeCntNext, eeLocNext, pendNext, testNext};
      {isAddr, rdMode, pendOk, strReg} <= {isAddrNext, rdModeNext, pendOkNext, strNext};
      sdaOeN <= sdaOeNNext;
      sclOeN <= sclOeNNext;
    end
  end

  // customer storage sits in flops; contents are lost with power
  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memAddr] <= shReg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer bytes: count, data low byte first, then PEC; the test command sends its byte and PEC with no count
  logic [111:0] blk;
  logic [7:0] len;
  logic [31:0] hoursReg, hoursNext;
  logic known;
  always_comb
  begin
    blk = '0;
    len = 8'h00;
    known = 1'b1;
    txByte = 8'hFF;
    unique case (cmdReg)
      rcmr_pkg::CMD_FAN:
        if (fanPresent)
        begin
          blk[47:0] = {meas.fan2Rpm, meas.fan1Rpm, meas.fanPct};
          len = rcmr_pkg::LEN_FAN;
        end
      rcmr_pkg::CMD_INPUT:
      begin
        blk = {meas.pwrIn, meas.iPh, meas.vPh};
        len = rcmr_pkg::LEN_INPUT;
      end
      rcmr_pkg::CMD_FWREV:
      begin
        blk[23:0] = meas.fwRev;
        len = rcmr_pkg::LEN_FWREV;
      end
      rcmr_pkg::CMD_TIMER:
      begin
        blk[31:0] = hoursReg;
        len = rcmr_pkg::LEN_TIMER;
      end
      rcmr_pkg::CMD_EEPROM: len = eeCnt;
      default: known = 1'b0;
    endcase
    if (cmdReg == rcmr_pkg::CMD_TEST)
      txByte = (rIdx == 8'h00) ? testReg : crcReg;
    else if (known)
    begin
      if (rIdx == 8'h00)
        txByte = len;
      else if (rIdx <= len)
        txByte = (cmdReg == rcmr_pkg::CMD_EEPROM) ? mem[7'(eeLoc + 7'(rIdx - 8'h01))]
                                                  : blk[{4'(rIdx - 8'h01), 3'b000} +: 8];
      else if (rIdx == len + 8'h01)
        txByte = crcReg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run hours, start-up current hold, status outputs
  logic [39:0] preReg, preNext;
  logic [31:0] ccReg, ccNext;
  logic [7:0] alarmNext;
  always_comb
  begin
    preNext = preReg + 40'h0000000001;
    hoursNext = hoursReg;
    if (preReg == 40'(HOUR_CYC - 1))
    begin
      preNext = '0;
      hoursNext = hoursReg + 32'h00000001;
    end
    ccNext = (ccReg < CC_HOLD_CYC) ? ccReg + 32'h00000001 : ccReg;
    alarmNext = {alarmIn.powerLimit, alarmIn.primaryFault, alarmIn.overtempShutdownFlag,
                 ({1'b0, tempC} + rcmr_pkg::OT_WARN_MARGIN_C) >= {1'b0, otShutLimit},
                 alarmIn.inOvercurrent, alarmIn.overvoltageShutdownFlag,
                 alarmIn.outputVoltageRangeFlag, alarmIn.inputVoltageRangeFlag};
  end

  // hours restart at reset: no non-volatile copy is held in this block
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {preReg, hoursReg, ccReg, alarmByteOne} <= '0;
      {oringTestReq, oringFailNote, unitFault, autoRestart, ccHold, overloadTrip} <= '0;
    end
    else
    begin
      {preReg, hoursReg, ccReg, alarmByteOne} <= {preNext, hoursNext, ccNext, alarmNext};
      oringTestReq <= testReg[rcmr_pkg::TB_ORING];
      oringFailNote <= oringFail;
      unitFault <= internalFault;
      autoRestart <= !latchOffCfg;
      ccHold <= overload && ccReg < CC_HOLD_CYC;
      overloadTrip <= overload && ccReg >= CC_HOLD_CYC;
    end
  end

  logic testLed;
  rcmr_blink #(.ON_CYC(LEDTEST_ON_CYC), .OFF_CYC(LEDTEST_OFF_CYC)) uLedTest (
    .clk(clk),
    .rst(rst),
    .en(testReg[rcmr_pkg::TB_LEDTEST]),
    .led(testLed)
  );
  assign lampTestLeds = {4{testLed}};
  rcmr_blink #(.ON_CYC(SERVICE_ON_CYC), .OFF_CYC(SERVICE_OFF_CYC)) uService (
    .clk(clk),
    .rst(rst),
    .en(testReg[rcmr_pkg::TB_SERVICE]),
    .led(serviceLed)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_OT_WARN: assert property (alarmByteOne[rcmr_pkg::AB_OTWARN] ==
    ({1'b0, $past(tempC)} + 9'h005 >= {1'b0, $past(otShutLimit)}))
    else $error("warning flag wrong");
  AST_FAN_COUNT: assert property (stReg == rcmr_pkg::ST_ACKOUT && rdMode && sclFall
    && cmdReg == rcmr_pkg::CMD_FAN && fanPresent |=> txCur == 8'h06)
    else $error("fan count not 6");
  AST_FAN_ABSENT: assert property (stReg == rcmr_pkg::ST_ACKOUT && rdMode && sclFall
    && cmdReg == rcmr_pkg::CMD_FAN && !fanPresent |=> txCur == 8'h00)
    else $error("absent fan not 0x00");
  AST_INPUT_COUNT: assert property (stReg == rcmr_pkg::ST_ACKOUT && rdMode && sclFall
    && cmdReg == rcmr_pkg::CMD_INPUT |=> txCur == 8'h0E)
    else $error("input count not 14");
  AST_STRETCH: assert property (stReg == rcmr_pkg::ST_ACKOUT && sclFall && !stopCond
    && !startCond && testReg[7] |=> !sclOeN [*8])
    else $error("stretch missing");
  AST_NO_STRETCH: assert property (strReg == 0 && !testReg[7] |=> sclOeN)
    else $error("stretch without request");
  AST_NACK_END: assert property (stReg == rcmr_pkg::ST_ACKIN && sclRise && sdaS2
    && !startCond && !stopCond |=> stReg == rcmr_pkg::ST_IDLE ##1 sdaOeN)
    else $error("nack did not end read");
  AST_LED_OFF: assert property (!testReg[0] |=> lampTestLeds == 4'h0)
    else $error("test leds not off");
  AST_SVC_OFF: assert property (!testReg[1] |=> !serviceLed)
    else $error("service led not off");
  AST_FAULT: assert property (oringFail && !internalFault |=> !unitFault)
    else $error("oring failure raised fault");
  AST_RESTART: assert property (latchOffCfg |=> !autoRestart)
    else $error("restart policy wrong");
  AST_CC: assert property (overload && ccReg >= CC_HOLD_CYC |=> overloadTrip && !ccHold)
    else $error("overload not tripped");
  COV_READ_PEC: cover property (stReg == rcmr_pkg::ST_ACKIN && sclRise && sdaS2);
  COV_EE_WRITE: cover property (memWe);
  COV_TEST_SET: cover property ($rose(testReg[0]));
  COV_STRETCH: cover property ($fell(sclOeN));
endmodule
`default_nettype wire

// ---- test/rcmr_host.sv ----
// rcmr_host: SMBus host model that bit-bangs the responder over open-drain lines.
// assumes the bench clock drives it; one SCL period is 8 cycles (320 ns).
`default_nettype none
module rcmr_host (
  input wire logic clk,    // bench clock
  input wire logic sclOeN, // device clock pull, low active
  input wire logic sdaOeN, // device data pull, low active
  output logic sclLine,    // bus clock wire level
  output logic sdaLine     // bus data wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl = 1'b1;
  logic sda = 1'b1;
  int stretch = 0;
  int hung = 0;
  // pull-ups: a released line reads high, never the last driven value
  assign sclLine = scl & sclOeN;
  assign sdaLine = sda & sdaOeN;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // releases SCL and waits out a stretch, bounded; every rise goes through here
  task automatic rise();
    int n;
    n = 0;
    scl <= 1'b1;
    cyc(1);
    while (!sclLine && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n == 400)
      hung = 1;
    if (n > stretch)
      stretch = n;
  endtask
  // data changes only while SCL is low
  task automatic bitx(input logic b, output logic r);
    scl <= 1'b0;
    cyc(1);
    sda <= b;
    cyc(3);
    rise();
    cyc(3);
    r = sdaLine;
  endtask
  task automatic start();
    sda <= 1'b0;
    cyc(4);
  endtask
  // a stretch after the last device ACK must end before the edge on SDA
  task automatic rstart();
    scl <= 1'b0;
    cyc(1);
    sda <= 1'b1;
    cyc(3);
    rise();
    cyc(3);
    start();
  endtask
  task automatic stop();
    scl <= 1'b0;
    cyc(1);
    sda <= 1'b0;
    cyc(3);
    rise();
    cyc(3);
    sda <= 1'b1;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_rectifier_mfr_command_responder.sv ----
// tb_rectifier_mfr_command_responder: random and corner traffic against the responder.
// assumes rcmr_host as bus partner and shortened timing parameters.
`default_nettype none
module tb_rectifier_mfr_command_responder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LON = 70, LOFF = 20, SON = 10, STR = 20, HR = 50;
  logic clk = 1'b0, rst = 1'b1, fanPresent = 1'b1, internalFault = 1'b0;
  logic oringFail = 1'b0, latchOffCfg = 1'b0, overload = 1'b1;
  logic [7:0] tempC = 8'h00, otShutLimit = 8'hFF, alarmByteOne;
  rcmr_pkg::rcmr_meas_t meas = '0;
  rcmr_pkg::rcmr_alarm_in_t alarmIn = '0;
  logic sclOeN, sdaOeN, serviceLed, oringTestReq, oringFailNote, unitFault;
  logic autoRestart, ccHold, overloadTrip;
  logic [3:0] lampTestLeds;
  wire logic sclLine, sdaLine;
  logic [31:0] seed = 32'hEBD98B42;
  logic [7:0] wq[$], ex[$], got[$];
  int failCount = 0, nTests = 0, cyc = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  rcmr_host host (.clk(clk), .sclOeN(sclOeN), .sdaOeN(sdaOeN), .sclLine(sclLine),
    .sdaLine(sdaLine));
  rcmr_responder #(.LEDTEST_ON_CYC(LON), .LEDTEST_OFF_CYC(LOFF), .SERVICE_ON_CYC(SON),
    .SERVICE_OFF_CYC(SON), .STRETCH_CYC(STR), .CC_HOLD_CYC(200), .HOUR_CYC(HR)) DUT (
    .clk(clk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sclOeN(sclOeN),
    .sdaOeN(sdaOeN), .meas(meas), .fanPresent(fanPresent), .tempC(tempC),
    .otShutLimit(otShutLimit), .alarmIn(alarmIn), .internalFault(internalFault),
    .oringFail(oringFail), .latchOffCfg(latchOffCfg), .overload(overload),
    .alarmByteOne(alarmByteOne), .lampTestLeds(lampTestLeds), .serviceLed(serviceLed),
    .oringTestReq(oringTestReq), .oringFailNote(oringFailNote), .unitFault(unitFault),
    .autoRestart(autoRestart), .ccHold(ccHold), .overloadTrip(overloadTrip));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? (x << 1) ^ 8'h07 : x << 1;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (failCount == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic void p16(input logic [15:0] v);
    ex.push_back(v[7:0]);
    ex.push_back(v[15:8]);
  endfunction
  // n bytes read after a repeated start (0: plain write); pw 1 good PEC, 2 bad PEC
  task automatic xfer(input int n, input int pw, input int nc);
    logic [7:0] pc, d;
    logic a;
    pc = 8'h00;
    got.delete();
    wq.push_front({rcmr_pkg::SLAVE_ADDR, 1'b0});
    foreach (wq[i]) pc = crc(pc, wq[i]);
    if (pw > 0)
      wq.push_back(pc ^ 8'(pw - 1));
    host.start();
    foreach (wq[i])
    begin
      host.wr(wq[i], a);
      if (i < 2)
        chk("ack", 1, a);
    end
    if (n > 0)
    begin
      host.rstart();
      host.wr({rcmr_pkg::SLAVE_ADDR, 1'b1}, a);
      pc = crc(pc, {rcmr_pkg::SLAVE_ADDR, 1'b1});
      for (int i = 0; i < n; i++)
      begin
        host.rd(i == n - 1, d);
        got.push_back(d);
        if (i < n - 1)
          pc = crc(pc, d);
      end
      chk("pec", pc, got[n - 1]);
      for (int i = 0; i < nc; i++)
        chk("byte", ex[i], got[i]);
    end
    host.stop();
    wq.delete();
    if (host.hung)
    begin
      failCount++;
      summarize();
    end
  endtask
  task automatic tbw(input logic [7:0] v, input int pw);
    wq = {rcmr_pkg::CMD_TEST, v};
    xfer(0, pw, 0);
  endtask
  task automatic rb(input logic [7:0] v);
    ex = {v};
    wq = {rcmr_pkg::CMD_TEST};
    xfer(2, 0, 1);
  endtask
  // counts cycles while the lamp stays at level v; a stuck lamp ends the run
  task automatic lvl(input int s, input logic v, output int n);
    n = 0;
    while ((s ? serviceLed : lampTestLeds[0]) === v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
    begin
      failCount++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [191:0] w;
    logic [7:0] lm, v;
    int n, c0;
    w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    meas <= w[183:0];
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("idle", 32'h7, {sclOeN, sdaOeN, autoRestart});
    repeat (100) @(posedge clk);
    chk("hold", 32'h2, {ccHold, overloadTrip});
    repeat (150) @(posedge clk);
    chk("trip", 32'h1, {ccHold, overloadTrip});
    overload <= 1'b0;
    latchOffCfg <= 1'b1;
    repeat (3) @(posedge clk);
    chk("auto", 0, autoRestart);
    for (int i = 0; i < 6; i++)
    begin
      lm = 8'(rnd() % 200 + 20);
      v = lm - 8'(4 + i % 3);
      otShutLimit <= lm;
      tempC <= v;
      alarmIn <= 7'(rnd());
      repeat (4) @(posedge clk);
      chk("alarm", {alarmIn[6:4], v + 8'h05 >= lm, alarmIn[3:0]}, alarmByteOne);
    end
    ex = {rcmr_pkg::LEN_FAN};
    p16(meas.fanPct);
    p16(meas.fan1Rpm);
    p16(meas.fan2Rpm);
    wq = {rcmr_pkg::CMD_FAN};
    xfer(8, 0, 7);
    ex = {rcmr_pkg::LEN_INPUT};
    for (int k = 0; k < 3; k++)
      p16(meas.vPh[k]);
    for (int k = 0; k < 3; k++)
      p16(meas.iPh[k]);
    p16(meas.pwrIn);
    wq = {rcmr_pkg::CMD_INPUT};
    xfer(16, 0, 15);
    ex = {rcmr_pkg::LEN_FWREV, meas.fwRev[0], meas.fwRev[1], meas.fwRev[2]};
    wq = {rcmr_pkg::CMD_FWREV};
    xfer(5, 0, 4);
    ex = {rcmr_pkg::LEN_TIMER};
    wq = {rcmr_pkg::CMD_TIMER};
    c0 = cyc;
    xfer(6, 0, 1);
    w[31:0] = {got[4], got[3], got[2], got[1]};
    chk("hours", 1, w[31:0] + 1 >= c0 / HR && w[31:0] <= cyc / HR + 1);
    fanPresent <= 1'b0;
    ex = {8'h00};
    wq = {rcmr_pkg::CMD_FAN};
    xfer(2, 0, 1);
    for (int i = 0; i < 2; i++)
    begin
      lm = i ? 8'(rnd() % 124) : 8'h7C;
      ex = {8'h04};
      wq = {rcmr_pkg::CMD_EEPROM, lm, 8'h04};
      repeat (4)
      begin
        v = 8'(rnd());
        wq.push_back(v);
        ex.push_back(v);
      end
      xfer(0, 1, 0);
      wq = {rcmr_pkg::CMD_EEPROM, lm, 8'h04};
      xfer(6, 0, 5);
    end
    tbw(8'h01, 1);
    // the lamp register only settles one edge after the stop
    @(posedge clk);
    lvl(0, 1'b1, n);
    lvl(0, 1'b0, n);
    chk("ledoff", LOFF, n);
    chk("leds", 32'hF, lampTestLeds);
    lvl(0, 1'b1, n);
    chk("ledon", LON, n);
    tbw(8'h00, 1);
    repeat (3) @(posedge clk);
    chk("ledstop", 0, lampTestLeds);
    tbw(8'h02, 1);
    @(posedge clk);
    lvl(1, 1'b1, n);
    lvl(1, 1'b0, n);
    chk("svcoff", SON, n);
    lvl(1, 1'b1, n);
    chk("svcon", SON, n);
    tbw(8'h00, 1);
    repeat (3) @(posedge clk);
    chk("svcstop", 0, serviceLed);
    tbw(8'h10, 1); // single unit on this bus, tested alone
    rb(8'h10);
    oringFail <= 1'b1;
    repeat (30) @(posedge clk); // scaled settle time before the result is read
    chk("oring", 32'h6, {oringTestReq, oringFailNote, unitFault});
    internalFault <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fault", 1, unitFault);
    tbw(8'h03, 2);
    rb(8'h10);
    tbw(8'h80, 1);
    host.stretch = 0;
    rb(8'h80);
    chk("stretch", 1, host.stretch >= STR - 6 && host.stretch <= STR + 6);
    tbw(8'h00, 1);
    host.stretch = 0;
    rb(8'h00);
    chk("nostretch", 0, host.stretch);
    summarize();
  end
endmodule
`default_nettype wire
